// [inc/csm_pkg.sv]
// constants, field layout and carrier types for the channel scan mux sequencer
// assumes a single mclk domain and a 32-bit axi4-lite register port
package csm_pkg;
   localparam int NCHAN = 7;
   localparam int CH_W = 3;
   localparam int WORD_W = 12;
   localparam int LATENCY = 7;
   localparam int DLL_LOCK_CYCLES = 8;
   localparam int DELAY_DEPTH = 8;
   localparam int DELAY_AW = 3;

   localparam logic [CH_W-1:0] CH_A = 3'h0;
   localparam logic [CH_W-1:0] CH_AUX = 3'h6;
   localparam logic [CH_W-1:0] CH_LAST = 3'h6;

   localparam logic [31:0] ADDR_CHAN = 32'h0000000c;
   localparam logic [31:0] ADDR_CLOCK = 32'h00000010;
   localparam logic [31:0] ADDR_FILT = 32'h00000014;
   localparam logic [31:0] ADDR_STAT = 32'h00000018;

   localparam int CHAN_CODE_LSB = 0;
   localparam int CHAN_CODE_W = 4;
   localparam int CHAN_KEEP_BIT = 6;
   localparam int CLK_DCS_BIT = 0;
   localparam int CLK_RELOCK_BIT = 1;
   localparam int FLT_DIV4_BIT = 0;
   localparam int FLT_MULT_LSB = 1;
   localparam int FLT_MULT_W = 3;
   localparam int FLT_TUNE_BIT = 4;
   localparam int STAT_CHAN_LSB = 0;
   localparam int STAT_COUNT_LSB = 4;
   localparam int STAT_LOCK_BIT = 8;
   localparam int STAT_TUNE_BIT = 9;

   localparam logic [3:0] CHAN_CODE_RST = 4'h0;
   localparam logic [3:0] CODE_ALL_MAIN = 4'ha;
   localparam logic CHAN_KEEP_RST = 1'b0;
   localparam logic DCS_RST = 1'b1;
   localparam logic DIV4_RST = 1'b0;
   localparam logic [2:0] MULT_RST = 3'h3;
   localparam logic [2:0] MULT_MAX = 3'h6;
   localparam logic TUNE_RST = 1'b0;

   localparam logic [13:0] FINE_OFFSET = 14'h0080;
   localparam logic [13:0] FULL_SCALE = 14'h0fff;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [3:0] coarse;
      logic [8:0] fine;
   } csm_stage_t;

   typedef struct packed {
      logic [WORD_W-1:0] word;
      logic [CH_W-1:0] chan;
      logic frame;
   } csm_tag_t;

   typedef struct packed {
      logic tune_en;
      logic div4;
      logic [2:0] mult;
   } csm_aaf_t;

   // enable code to channel mask, bit 0 = a ... bit 5 = f, bit 6 = aux
   function automatic logic [NCHAN-1:0] ch_mask(input logic [3:0] code);
      case (code)
         4'h0: ch_mask = 7'h01;
         4'h1: ch_mask = 7'h03;
         4'h2: ch_mask = 7'h07;
         4'h3: ch_mask = 7'h0f;
         4'h4: ch_mask = 7'h1f;
         4'h5: ch_mask = 7'h40;
         4'h6: ch_mask = 7'h41;
         4'h7: ch_mask = 7'h43;
         4'h8: ch_mask = 7'h47;
         4'h9: ch_mask = 7'h4f;
         CODE_ALL_MAIN: ch_mask = 7'h3f;
         4'hb: ch_mask = 7'h5f;
         4'hc: ch_mask = 7'h7f;
         default: ch_mask = 7'h01;
      endcase
   endfunction : ch_mask

   function automatic logic [CH_W-1:0] ch_count(input logic [NCHAN-1:0] mask);
      ch_count = 3'h0;
      for (int i = 0; i < NCHAN; i++) begin
         ch_count = ch_count + {2'h0, mask[i]};
      end
   endfunction : ch_count
endpackage : csm_pkg

// [hw/csm_delay_mem.sv]
// small circular memory for the output pipeline, one write per cycle
// assumes the read address never equals the write address in the same cycle
`timescale 1ns/1ps
`default_nettype none
module csm_delay_mem #(
   parameter int W = 16,
   parameter int DEPTH = 8,
   parameter int AW = 3
) (
   input wire logic mclk, // sample clock
   input wire logic [AW-1:0] waddr, // write slot
   input wire logic [W-1:0] wdata, // word to store
   input wire logic [AW-1:0] raddr, // read slot
   output logic [W-1:0] rdata_q // registered read data
);
   logic [W-1:0] mem [DEPTH];

   always_ff @(posedge mclk) begin
      mem[waddr] <= wdata;
   end

   always_ff @(posedge mclk) begin
      rdata_q <= mem[raddr];
   end
endmodule : csm_delay_mem
`default_nettype wire

// [hw/csm_lock_timer.sv]
// lock wait for the stabilizer loop after a clock rate change
// assumes start is a one-cycle pulse on mclk
`timescale 1ns/1ps
`default_nettype none
module csm_lock_timer #(
   parameter int CYCLES = 8
) (
   input wire logic mclk, // sample clock
   input wire logic srst, // sync reset, high
   input wire logic enable, // stabilizer on
   input wire logic start, // restart the lock wait
   output logic locked_q // loop taken as locked
);
   logic [7:0] cnt_q;

   always_ff @(posedge mclk) begin
      if (srst || start || !enable) begin
         cnt_q <= 8'h00;
      end else if (cnt_q != 8'(CYCLES)) begin
         cnt_q <= cnt_q + 8'h01;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst || start || !enable) begin
         locked_q <= 1'b0;
      end else begin
         locked_q <= (cnt_q == 8'(CYCLES - 1)) || locked_q;
      end
   end
endmodule : csm_lock_timer
`default_nettype wire

// [hw/csm_sequencer.sv]
// channel scan sequencer: mux scan, correction, output pipeline, axi4-lite registers
// assumes the analog core presents stage codes for the held channel each cycle
// Notes on behaviour
// - one clock per enabled channel, then advance
// - selector steps on the sampling edge
// - channel a converted first, except aux-only
// - aux always takes the last slot
// - power down unselected channels unless keep bit
// - frame marker with channel a word in multi-channel scans
// - word appears seven clocks after sampling
// - code 1010 enables channels a through f
// - sample on rising clock edge
// - merge stage codes into twelve-bit word
// - stabilizer control, switchable off
// - eight clocks for loop lock after change
// - default cutoff one third or quarter
// - cutoff multiplier 0.7 to 1.3
// - tuning off unless enabled by software
// - per-channel rate divided by enabled count
// - remaining words follow on consecutive clocks
`timescale 1ns/1ps
`default_nettype none
module csm_sequencer #(
   parameter int LAT = csm_pkg::LATENCY,
   parameter int LOCK_CYCLES = csm_pkg::DLL_LOCK_CYCLES
) (
   input wire logic mclk, // 40 mhz sample clock
   input wire logic srst, // sync reset, high
   input wire logic [31:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte enables
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [31:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire csm_pkg::csm_stage_t stage_in, // stage codes from analog core
   output logic [2:0] mux_sel_q, // selector position
   output logic [6:0] chan_pd_q, // per-channel power down
   output logic dcs_en_q, // duty_cycle_stabilizer on
   output csm_pkg::csm_aaf_t aaf_ctrl_q, // antialias_filter control
   output logic [11:0] data_out_q, // parallel converter word
   output logic frame_marker_q // high with channel a word when more than one channel is enabled
);
   // scan next enabled channel in ascending order, wrapping to the first
   function automatic logic [2:0] next_chan(input logic [6:0] mask, input logic [2:0] cur);
      logic [2:0] pick;
      logic found;
      int idx;
      pick = cur;
      found = 1'b0;
      for (int i = 1; i <= csm_pkg::NCHAN; i++) begin
         idx = (int'(cur) + i) % csm_pkg::NCHAN;
         if (!found && mask[idx]) begin
            pick = 3'(idx);
            found = 1'b1;
         end
      end
      next_chan = pick;
   endfunction : next_chan

   logic [3:0] chan_code_q;
   logic chan_keep_q;
   logic [6:0] mask;
   logic [2:0] n_enabled;
   logic multi;
   logic relock;
   logic dll_locked;

   assign mask = csm_pkg::ch_mask(chan_code_q);
   assign n_enabled = csm_pkg::ch_count(mask);
   assign multi = n_enabled > 3'h1;

   // ---- register bus ----
   logic aw_have_q, w_have_q;
   logic [31:0] aw_addr_q, w_data_q;
   logic [3:0] w_strb_q;
   logic aw_fire, w_fire, ar_fire, do_write;
   logic [31:0] wr_addr, wr_data;
   logic [3:0] wr_strb;
   logic aw_have_d, w_have_d, bvalid_d, rvalid_d;
   logic wr_hit;

   assign aw_fire = s_axi_awvalid && s_axi_awready;
   assign w_fire = s_axi_wvalid && s_axi_wready;
   assign ar_fire = s_axi_arvalid && s_axi_arready;
   assign wr_addr = aw_fire ? s_axi_awaddr : aw_addr_q;
   assign wr_data = w_fire ? s_axi_wdata : w_data_q;
   assign wr_strb = w_fire ? s_axi_wstrb : w_strb_q;
   assign do_write = (aw_have_q || aw_fire) && (w_have_q || w_fire) && !s_axi_bvalid;
   assign wr_hit = (wr_addr == csm_pkg::ADDR_CHAN) || (wr_addr == csm_pkg::ADDR_CLOCK) ||
                   (wr_addr == csm_pkg::ADDR_FILT) || (wr_addr == csm_pkg::ADDR_STAT);

   always_comb begin
      aw_have_d = (aw_have_q || aw_fire) && !do_write;
      w_have_d = (w_have_q || w_fire) && !do_write;
      bvalid_d = do_write || (s_axi_bvalid && !s_axi_bready);
      rvalid_d = ar_fire || (s_axi_rvalid && !s_axi_rready);
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
      end else begin
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         s_axi_awready <= !aw_have_d && !bvalid_d;
         s_axi_wready <= !w_have_d && !bvalid_d;
         s_axi_bvalid <= bvalid_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         aw_addr_q <= 32'h00000000;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         s_axi_bresp <= csm_pkg::RESP_OKAY;
      end else begin
         if (aw_fire) begin
            aw_addr_q <= s_axi_awaddr;
         end
         if (w_fire) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bresp <= wr_hit ? csm_pkg::RESP_OKAY : csm_pkg::RESP_SLVERR;
         end
      end
   end

   // configuration registers, all fields live in byte lane 0
   always_ff @(posedge mclk) begin
      if (srst) begin
         chan_code_q <= csm_pkg::CHAN_CODE_RST;
         chan_keep_q <= csm_pkg::CHAN_KEEP_RST;
         dcs_en_q <= csm_pkg::DCS_RST;
         aaf_ctrl_q.div4 <= csm_pkg::DIV4_RST;
         aaf_ctrl_q.mult <= csm_pkg::MULT_RST;
         aaf_ctrl_q.tune_en <= csm_pkg::TUNE_RST;
      end else if (do_write && wr_strb[0]) begin
         if (wr_addr == csm_pkg::ADDR_CHAN) begin
            chan_code_q <= wr_data[csm_pkg::CHAN_CODE_LSB +: csm_pkg::CHAN_CODE_W];
            chan_keep_q <= wr_data[csm_pkg::CHAN_KEEP_BIT];
         end
         if (wr_addr == csm_pkg::ADDR_CLOCK) begin
            dcs_en_q <= wr_data[csm_pkg::CLK_DCS_BIT];
         end
         if (wr_addr == csm_pkg::ADDR_FILT) begin
            aaf_ctrl_q.div4 <= wr_data[csm_pkg::FLT_DIV4_BIT];
            // out-of-range multiplier codes fall back to unity
            aaf_ctrl_q.mult <= (wr_data[csm_pkg::FLT_MULT_LSB +: csm_pkg::FLT_MULT_W] > csm_pkg::MULT_MAX) ?
                               csm_pkg::MULT_RST : wr_data[csm_pkg::FLT_MULT_LSB +: csm_pkg::FLT_MULT_W];
            aaf_ctrl_q.tune_en <= wr_data[csm_pkg::FLT_TUNE_BIT];
         end
      end
   end

   // a relock strobe marks a clock rate change made by software
   assign relock = do_write && wr_strb[0] && (wr_addr == csm_pkg::ADDR_CLOCK) &&
                   wr_data[csm_pkg::CLK_RELOCK_BIT];

   csm_lock_timer #(
      .CYCLES(LOCK_CYCLES)
   ) u_lock (
      .mclk(mclk),
      .srst(srst),
      .enable(dcs_en_q),
      .start(relock),
      .locked_q(dll_locked)
   );

   // read channel
   logic [31:0] rd_word;
   logic rd_hit;

   always_comb begin
      rd_word = 32'h00000000;
      rd_hit = 1'b1;
      case (s_axi_araddr)
         csm_pkg::ADDR_CHAN: begin
            rd_word[csm_pkg::CHAN_CODE_LSB +: csm_pkg::CHAN_CODE_W] = chan_code_q;
            rd_word[csm_pkg::CHAN_KEEP_BIT] = chan_keep_q;
         end
         csm_pkg::ADDR_CLOCK: begin
            rd_word[csm_pkg::CLK_DCS_BIT] = dcs_en_q;
         end
         csm_pkg::ADDR_FILT: begin
            rd_word[csm_pkg::FLT_DIV4_BIT] = aaf_ctrl_q.div4;
            rd_word[csm_pkg::FLT_MULT_LSB +: csm_pkg::FLT_MULT_W] = aaf_ctrl_q.mult;
            rd_word[csm_pkg::FLT_TUNE_BIT] = aaf_ctrl_q.tune_en;
         end
         csm_pkg::ADDR_STAT: begin
            rd_word[csm_pkg::STAT_CHAN_LSB +: csm_pkg::CH_W] = mux_sel_q;
            rd_word[csm_pkg::STAT_COUNT_LSB +: csm_pkg::CH_W] = n_enabled;
            rd_word[csm_pkg::STAT_LOCK_BIT] = dll_locked;
            rd_word[csm_pkg::STAT_TUNE_BIT] = aaf_ctrl_q.tune_en;
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= csm_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= !rvalid_d;
         s_axi_rvalid <= rvalid_d;
         if (ar_fire) begin
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? csm_pkg::RESP_OKAY : csm_pkg::RESP_SLVERR;
         end
      end
   end

   // ---- mux scan ----
   // one step per rising clock edge, the same edge on which the stage codes are sampled
   always_ff @(posedge mclk) begin
      if (srst) begin
         mux_sel_q <= csm_pkg::CH_A;
      end else begin
         mux_sel_q <= next_chan(mask, mux_sel_q);
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         chan_pd_q <= 7'h00;
      end else begin
         chan_pd_q <= chan_keep_q ? 7'h00 : ~mask;
      end
   end

   // ---- correction and output pipeline ----
   logic [13:0] merged;
   logic [11:0] corrected;
   csm_pkg::csm_tag_t wr_tag, rd_tag;
   logic [2:0] wr_ptr_q;
   logic [3:0] fill_q;

   // stage codes overlap by one bit; the offset removes the redundancy
   assign merged = {2'h0, stage_in.coarse, 8'h00} + {5'h00, stage_in.fine} - csm_pkg::FINE_OFFSET;
   assign corrected = merged[13] ? 12'h000 :
                      (merged > csm_pkg::FULL_SCALE) ? csm_pkg::FULL_SCALE[11:0] : merged[11:0];

   always_comb begin
      wr_tag.word = corrected;
      wr_tag.chan = mux_sel_q;
      // single-channel scans carry no marker
      wr_tag.frame = (mux_sel_q == csm_pkg::CH_A) && multi;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         wr_ptr_q <= 3'h0;
      end else begin
         wr_ptr_q <= wr_ptr_q + 3'h1;
      end
   end

   csm_delay_mem #(
      .W($bits(csm_pkg::csm_tag_t)),
      .DEPTH(csm_pkg::DELAY_DEPTH),
      .AW(csm_pkg::DELAY_AW)
   ) u_delay (
      .mclk(mclk),
      .waddr(wr_ptr_q),
      .wdata(wr_tag),
      .raddr(wr_ptr_q - 3'(LAT - 1)),
      .rdata_q(rd_tag)
   );

   // memory holds garbage after reset, so outputs wait until it has filled
   always_ff @(posedge mclk) begin
      if (srst) begin
         fill_q <= 4'h0;
      end else if (fill_q != 4'(LAT)) begin
         fill_q <= fill_q + 4'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         data_out_q <= 12'h000;
         frame_marker_q <= 1'b0;
      end else if (fill_q == 4'(LAT)) begin
         data_out_q <= rd_tag.word;
         frame_marker_q <= rd_tag.frame;
      end
   end
endmodule : csm_sequencer
`default_nettype wire

// [tb/csm_sequencer_assertions.sv]
// checker for csm_sequencer: scan order, word timing, frame marker, bus answers
// assumes it is bound to csm_sequencer and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module csm_sequencer_assertions #(
   parameter int LAT = 7,
   parameter int LOCK_CYCLES = 8
) (
   input wire logic mclk, // sample clock
   input wire logic srst, // sync reset
   input wire csm_pkg::csm_stage_t stage_in, // stage codes
   input wire logic [2:0] mux_sel_q, // selector
   input wire logic [11:0] data_out_q, // word out
   input wire logic frame_marker_q, // frame marker
   input wire logic s_axi_awvalid, // aw valid
   input wire logic s_axi_awready, // aw ready
   input wire logic s_axi_wvalid, // w valid
   input wire logic s_axi_wready, // w ready
   input wire logic s_axi_bvalid, // b valid
   input wire logic s_axi_bready, // b ready
   input wire logic [1:0] s_axi_bresp, // b response
   input wire logic s_axi_rvalid, // r valid
   input wire logic s_axi_rready // r ready
);
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   logic [4:0] fill_q;
   // pipeline checks wait until no word from before reset can show
   always_ff @(posedge mclk) begin
      if (srst) fill_q <= 5'h0;
      else if (fill_q != 5'h1f) fill_q <= fill_q + 5'h1;
   end
   function automatic logic [11:0] corr(input csm_pkg::csm_stage_t s);
      logic [13:0] v;
      v = {2'h0, s.coarse, 8'h00} + {5'h0, s.fine};
      if (v < csm_pkg::FINE_OFFSET) return 12'h000;
      v = v - csm_pkg::FINE_OFFSET;
      return (v > csm_pkg::FULL_SCALE) ? 12'hfff : v[11:0];
   endfunction : corr
   a_word_latency: assert property (
      fill_q >= 5'(LAT + 2) |-> data_out_q == corr($past(stage_in, LAT + 1)))
      else $error("word differs from sample taken seven clocks before");
   a_frame_on_a: assert property (
      fill_q >= 5'(LAT + 2) && frame_marker_q |-> $past(mux_sel_q, LAT + 1) == csm_pkg::CH_A)
      else $error("frame marker not on channel a word");
   a_frame_single: assert property (frame_marker_q |=> !frame_marker_q)
      else $error("frame marker longer than one word");
   a_aux_last: assert property (
      mux_sel_q == csm_pkg::CH_AUX |=> mux_sel_q == csm_pkg::CH_A || mux_sel_q == csm_pkg::CH_AUX)
      else $error("aux slot not last in scan");
   a_scan_ascend: assert property (
      1'b1 |=> mux_sel_q == csm_pkg::CH_A || mux_sel_q == csm_pkg::CH_AUX || mux_sel_q == $past(mux_sel_q) + 3'h1)
      else $error("selector left ascending order");
   a_b_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
      else $error("write response late");
   a_b_pulse: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_r_pulse: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response repeated");
   c_frame: cover property (frame_marker_q);
   c_aux: cover property (mux_sel_q == csm_pkg::CH_AUX);
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == csm_pkg::RESP_SLVERR);
endmodule : csm_sequencer_assertions
`default_nettype wire

// [tb/csm_capture_model.sv]
// capture side model: logic framing the parallel word stream
// assumes one word per mclk, marker on the channel a word
`timescale 1ns/1ps
`default_nettype none
module csm_capture_model (
   input wire logic mclk, // sample clock
   input wire logic srst, // sync reset
   input wire logic [11:0] data_out_q, // converter word
   input wire logic frame_marker_q, // frame start
   output logic [3:0] frame_len_q // words in last whole frame
);
   logic [3:0] run_q;
   // first length after reset is partial; the bench waits past it
   always_ff @(posedge mclk) begin
      if (srst) begin
         run_q <= 4'h0;
         frame_len_q <= 4'h0;
      end else if (frame_marker_q) begin
         frame_len_q <= run_q;
         run_q <= 4'h1;
      end else if (run_q != 4'hf) begin
         run_q <= run_q + 4'h1;
      end
   end
endmodule : csm_capture_model
`default_nettype wire

// [tb/csm_sequencer_tb.sv]
// self-checking bench: registers, scan order, frame marker, control outputs
// assumes csm_pkg, the design and csm_capture_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module csm_sequencer_tb;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, dcs_en_q, frame_marker_q;
   logic [1:0] s_axi_bresp, s_axi_rresp, pin = 2'h0;
   csm_pkg::csm_stage_t stage_in = '0;
   logic [2:0] mux_sel_q;
   logic [6:0] chan_pd_q;
   csm_pkg::csm_aaf_t aaf_ctrl_q;
   logic [11:0] data_out_q;
   logic [3:0] frame_len_q;
   int failures = 0, tests_run = 0, seed = 55338;
   always #12.5 mclk = ~mclk;
   csm_sequencer csm_sequencer_i (.mclk(mclk), .srst(srst), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .stage_in(stage_in), .mux_sel_q(mux_sel_q), .chan_pd_q(chan_pd_q),
      .dcs_en_q(dcs_en_q), .aaf_ctrl_q(aaf_ctrl_q), .data_out_q(data_out_q), .frame_marker_q(frame_marker_q));
   csm_capture_model csm_capture_model_i (.mclk(mclk), .srst(srst), .data_out_q(data_out_q),
      .frame_marker_q(frame_marker_q), .frame_len_q(frame_len_q));
   // pin 1 and 2 force the clamp corners at full scale and zero
   always @(posedge mclk) begin
      stage_in <= (pin == 2'h1) ? 13'h1fff : (pin == 2'h2) ? 13'h0000 : 13'($random(seed));
   end
   function automatic logic [6:0] exp_mask(input logic [3:0] c);
      logic [6:0] t [16];
      t = '{7'h01, 7'h03, 7'h07, 7'h0f, 7'h1f, 7'h40, 7'h41, 7'h43, 7'h47, 7'h4f, 7'h3f, 7'h5f, 7'h7f,
            7'h01, 7'h01, 7'h01};
      return t[c];
   endfunction : exp_mask
   task automatic chk(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1) begin
         failures++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask : chk
   task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (aw || w) begin
         @(posedge mclk);
         if (aw && s_axi_awready) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
   endtask : wr
   task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge mclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask : rd
   task automatic end_sim();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_sim
   initial begin
      repeat (20000) @(posedge mclk);
      failures++;
      $display("[ERR] %0t timeout", $time);
      end_sim();
   end
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic [6:0] m;
      logic [2:0] ord [$];
      int n, fc;
      repeat (20) @(posedge mclk);
      srst <= 1'b0;
      repeat (2) @(posedge mclk);
      chk(aaf_ctrl_q === 5'h03 && dcs_en_q === 1'b1, "control reset");
      rd(csm_pkg::ADDR_FILT, d, r);
      chk(d === 32'h6 && r === csm_pkg::RESP_OKAY, "filter read");
      rd(32'h40, d, r);
      chk(d === 32'h0 && r === csm_pkg::RESP_SLVERR, "unmapped read");
      wr(32'h40, 32'h1, r);
      chk(r === csm_pkg::RESP_SLVERR, "unmapped write");
      for (int c = 0; c < 16; c++) begin
         wr(csm_pkg::ADDR_CHAN, 32'(c), r);
         m = exp_mask(4'(c));
         ord.delete();
         for (int b = 0; b < 7; b++) if (m[b]) ord.push_back(3'(b));
         n = ord.size();
         pin <= 2'(c % 3);
         repeat (16) @(posedge mclk);
         chk(chan_pd_q === ~m, "power down mask");
         do @(posedge mclk); while (mux_sel_q !== ord[0]);
         fc = 0;
         for (int i = 1; i < 17; i++) begin
            @(posedge mclk);
            if (frame_marker_q === 1'b1) fc++;
            chk(mux_sel_q === ord[i % n], "scan order");
         end
         chk((n > 1) ? (fc > 0 && frame_len_q === 4'(n)) : (fc == 0), "frame marker");
         rd(csm_pkg::ADDR_STAT, d, r);
         chk(d[6:4] === 3'(n), "enabled count");
      end
      wr(csm_pkg::ADDR_CHAN, 32'h41, r);
      repeat (4) @(posedge mclk);
      chk(chan_pd_q === 7'h00, "keep powered");
      for (int k = 0; k < 8; k++) begin
         d = 32'(k);
         wr(csm_pkg::ADDR_FILT, {27'h0, d[0], d[2:0], d[1]}, r);
         repeat (2) @(posedge mclk);
         chk(aaf_ctrl_q === {d[0], d[1], (k == 7) ? 3'h3 : d[2:0]}, "filter control");
      end
      wr(csm_pkg::ADDR_CLOCK, 32'h0, r);
      rd(csm_pkg::ADDR_STAT, d, r);
      chk(dcs_en_q === 1'b0 && d[8] === 1'b0, "stabilizer off");
      wr(csm_pkg::ADDR_CLOCK, 32'h3, r);
      rd(csm_pkg::ADDR_STAT, d, r);
      chk(dcs_en_q === 1'b1 && d[8] === 1'b0, "lock wait");
      // status read is taken at the eighth edge after the strobe: still unlocked
      repeat (4) @(posedge mclk);
      rd(csm_pkg::ADDR_STAT, d, r);
      chk(d[8] === 1'b0, "lock too early");
      rd(csm_pkg::ADDR_STAT, d, r);
      chk(d[8] === 1'b1, "locked");
      end_sim();
   end
endmodule : csm_sequencer_tb
bind csm_sequencer csm_sequencer_assertions #(.LAT(LAT), .LOCK_CYCLES(LOCK_CYCLES))
   csm_sequencer_assertions_i (.mclk(mclk), .srst(srst), .stage_in(stage_in), .mux_sel_q(mux_sel_q),
   .data_out_q(data_out_q), .frame_marker_q(frame_marker_q), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire
